// ===== dv/ercc_top_test.sv
`include "ercc_defs.svh"

module ercc_top_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  logic        clk;
  logic        rst;
  logic        awv;
  logic        wv;
  logic        arv;
  logic        bry;
  logic        rry;
  logic [7:0]  awa;
  logic [7:0]  ara;
  logic [31:0] wd;
  logic        awr;
  logic        wrd;
  logic        arr;
  logic        bv;
  logic        rv;
  logic [1:0]  br;
  logic [1:0]  rr;
  logic [31:0] rdat;
  logic [1:0]  last_resp;
  logic [31:0] hl;
  logic [31:0] fo;
  logic [31:0] lo;
  logic [31:0] tab [15];
  int          mismatches;
  int          compares;
  localparam logic [31:0] full = 32'hFFFF_FFFF;

  // one-word overrides of the good setup, each breaking one check
  logic [3:0]  f_idx [20] = '{2, 2, 6, 5, 2, 2, 7, 2, 2, 2, 2, 11, 2, 2,
                              2, 9, 10, 2, 2, 2};
  logic [31:0] f_val [20] = '{32'h38, 32'h3F, 32'hF, 32'h5004, 32'h239,
    32'h139, 32'h1, 32'h3D, 32'h439, 32'h839, 32'h1039, 32'hFFFF_F000,
    32'h4039, 32'h29, 32'h19, 32'h3, 32'h8, 32'h8039, 32'h2039, 32'hB9};
  logic [7:0]  f_cs [20] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04,
    8'h05, 8'h06, 8'h07, 8'h07, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0B,
    8'h0C, 8'h0C, 8'h0D, 8'h0E};

  ercc_top ercc_top_inst (
    .CORE_CLK_I(clk), .SYS_RST_I(rst),
    .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
    .WVALID_I(wv), .WREADY_O(wrd), .WDATA_I(wd), .WSTRB_I(4'hF),
    .BVALID_O(bv), .BREADY_I(bry), .BRESP_O(br),
    .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
    .RVALID_O(rv), .RREADY_I(rry), .RDATA_O(rdat), .RRESP_O(rr)
  );

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  // a page fault reports through its own status bit, all else as gp
  function automatic logic [31:0] exp_status(input logic [7:0] cs);
    return {16'h0, cs, (cs == 8'h0E) ? 8'h05 : 8'h03};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ready is looked at before the edge, so the edge that takes it is known
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta;
    bit tw;
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    do begin
      @(negedge clk);
      ta |= awv && awr;
      tw |= wv && wrd;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!(ta && tw));
    do @(negedge clk); while (bv !== 1'b1);
    last_resp = br;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    d = rdat;
    last_resp = rr;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, m,
                    input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d & m);
  endtask

  // the command word is skipped so loading never starts a run
  task automatic load(input logic [31:0] t [15]);
    for (int k = 0; k < 15; k++) begin
      if (k != 1) wr(8'(k * 4), t[k]);
    end
  endtask

  task automatic go(input logic [31:0] e);
    logic [31:0] s;
    wr(`ERCC_OFF_CMD, 32'h1);
    do rd(`ERCC_OFF_STATUS, s); while (s[`ERCC_S_BUSY] === 1'b1);
    chk("status", e, s);
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] t [15];
    {rst, bry, rry} = 3'b111;
    {awv, wv, arv, awa, ara, wd} = '0;
    void'($urandom(68930));
    hl = ($urandom() & 32'h00FF_FFF0) | 32'h0000_0100;
    fo = $urandom() & 32'h000F_F000;
    lo = $urandom() & 32'h0000_FFFF;
    tab = '{32'h3, 32'h0, 32'h39, hl, 32'h0001_0000, 32'h5000,
            32'h00FF_FFFF, 32'h0, 32'h7, 32'hF, 32'h1, fo,
            fo + 32'h0010_0000, lo, lo};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`ERCC_OFF_STATUS, 32'h0, 32'hFFFF_FFFF, "status_rst");
    rc(8'h80, 32'h0, 32'hFFFF_FFFF, "unmapped_rd");
    chk("rd_resp", 32'h2, {30'h0, last_resp});
    wr(8'h80, 32'h1);
    chk("wr_resp", 32'h2, {30'h0, last_resp});
    // a leaf other than resume is ignored
    t = tab;
    t[0] = 32'h4;
    load(t);
    go(32'h0000_0009);
    // every fault leaves the pointer and feature control untouched
    for (int i = 0; i < 20; i++) begin
      t = tab;
      t[f_idx[i]] = f_val[i];
      load(t);
      go(exp_status(f_cs[i])); // to
      rc(`ERCC_OFF_XP_LO, 32'h0, full, "xp_lo");
      rc(`ERCC_OFF_XCR, t[9], full, "xcr");
    end
    // opt-out entry with the trap flag set beforehand
    t = tab;
    t[2] = 32'h79;
    load(t);
    wr(`ERCC_OFF_CMD, 32'h2);
    go(32'h1);
    rc(`ERCC_OFF_XP_LO, hl, full, "xp_lo");
    rc(`ERCC_OFF_XP_HI, 32'h0001_0000, full, "xp_hi");
    rc(`ERCC_OFF_FS, fo, full, "fs");
    rc(`ERCC_OFF_GS, tab[12], full, "gs");
    rc(`ERCC_OFF_FS_LIM, lo, full, "fs_lim");
    rc(`ERCC_OFF_GS_LIM, lo, full, "gs_lim");
    rc(`ERCC_OFF_SV_XCR, 32'hF, full, "sv_xcr");
    rc(`ERCC_OFF_XCR, 32'h7, full, "xcr");
    rc(`ERCC_OFF_DBG, 32'h2, 32'h7, "dbg_trap");
    rc(`ERCC_OFF_DBG, 32'h118, 32'h118, "dbg_bp");
    rc(`ERCC_OFF_DBG, 32'hE0, 32'hE0, "dbg_mon");
    rc(`ERCC_OFF_PERF, 32'h9000_0000, full, "perf");
    // a flag pop inside an opt-out enclave must not set the trap flag
    wr(`ERCC_OFF_CMD, 32'h2);
    rc(`ERCC_OFF_DBG, 32'h0, 32'h1, "dbg_trap_pop");
    wr(`ERCC_OFF_CMD, 32'h4);
    rc(`ERCC_OFF_DBG, 32'h1, 32'h1FD, "dbg_exit");
    rc(`ERCC_OFF_XCR, 32'hF, full, "xcr_exit");
    rc(`ERCC_OFF_FS, 32'h0, full, "fs_exit");
    wr(`ERCC_OFF_PERF, 32'h9000_0000);
    rc(`ERCC_OFF_PERF, 32'h0, full, "perf_clr");
    // opt-in entry in wide mode: limits are left as they were
    t = tab;
    t[2] = 32'h3F;
    t[4] = 32'h0;
    t[13] = lo ^ 32'h0000_00FF;
    load(t);
    go(32'h1);
    rc(`ERCC_OFF_XP_HI, 32'h0, full, "xp_hi_wide");
    rc(`ERCC_OFF_FS_LIM, lo, full, "fs_lim_wide");
    rc(`ERCC_OFF_DBG, 32'h10C, 32'h1FC, "dbg_optin");
    rc(`ERCC_OFF_PERF, 32'h0, full, "perf_optin");
    wr(`ERCC_OFF_CMD, 32'h8);
    rc(`ERCC_OFF_DBG, 32'h0, 32'h4, "dbg_retire");
    give_verdict();
  end

endmodule

// ===== hdl/ercc_top.sv
`include "ercc_defs.svh"

// Operation
// [RULE_01] leaf code 03h runs the resume
// [RULE_02] outside enclave gives general-protection zero
// [RULE_03] wide mode needs canonical handler pointer
// [RULE_04] protected mode handler within data limit
// [RULE_05] operand page fault raises page fault
// [RULE_06] misaligned or foreign operand faults
// [RULE_07] nonzero must-be-zero flag bits fault
// [RULE_08] mode must match wide mode attribute
// [RULE_09] bad, locked or shared structures fault
// [RULE_10] FS and GS inside data segment
// [RULE_11] DS, ES, CS, SS bases zero
// [RULE_12] legacy feature mask must equal three
// [RULE_13] FX support set, mask within control
// [RULE_14] save header clean, vector within mask
// [RULE_15] save frame invalid or busy faults
// [RULE_16] success stores handler pointer
// [RULE_17] save and rebuild FS and GS
// [RULE_18] swap extended feature control with mask
// [RULE_19] opt-out hides single-step trap flag
// [RULE_20] opt-in pends single-step after entry
// [RULE_21] breakpoint suppression by enclave range
// [RULE_22] opt-out suppresses monitoring, sets 60/63
// [RULE_23] faulting resume commits no state
module ercc_top (
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  // write address channel
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [7:0]  AWADDR_I,
  // write data channel
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  // write response channel
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  output logic [1:0]       BRESP_O,
  // read address channel
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  input  wire logic [7:0]  ARADDR_I,
  // read data channel
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O
);
  import ercc_pkg::*;

  ercc_state_t q;
  ercc_state_t d;
  ercc_cause_t cause;
  logic        wide;
  logic [32:0] fs_end;
  logic [32:0] gs_end;
  logic        rd_hit;
  logic [31:0] rd_val;
  logic        wr_hit;

  //--------------------------------------------------------------
  // byte-lane merge and read decode
  //--------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // read mux; command and unmapped offsets read zero
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (ARADDR_I)
      `ERCC_OFF_FUNC:    rd_val = q.func;
      `ERCC_OFF_CMD:     rd_val = 32'h0000_0000;
      `ERCC_OFF_COND:    rd_val = q.cond;
      `ERCC_OFF_HPTR_LO: rd_val = q.hptr_lo;
      `ERCC_OFF_HPTR_HI: rd_val = q.hptr_hi;
      `ERCC_OFF_CSP:     rd_val = q.csp;
      `ERCC_OFF_DS_LIM:  rd_val = q.ds_lim;
      `ERCC_OFF_TFLAGS:  rd_val = q.tflags;
      `ERCC_OFF_FMASK:   rd_val = q.fmask;
      `ERCC_OFF_XCR:     rd_val = q.xcr;
      `ERCC_OFF_XBV:     rd_val = q.xbv;
      `ERCC_OFF_FS_OFS:  rd_val = q.fs_ofs;
      `ERCC_OFF_GS_OFS:  rd_val = q.gs_ofs;
      `ERCC_OFF_FS_LOFS: rd_val = q.fs_lofs;
      `ERCC_OFF_GS_LOFS: rd_val = q.gs_lofs;
      `ERCC_OFF_STATUS:  rd_val = q.status;
      `ERCC_OFF_XP_LO:   rd_val = q.xp_lo;
      `ERCC_OFF_XP_HI:   rd_val = q.xp_hi;
      `ERCC_OFF_FS:      rd_val = q.fs;
      `ERCC_OFF_GS:      rd_val = q.gs;
      `ERCC_OFF_SV_FS:   rd_val = q.sv_fs;
      `ERCC_OFF_SV_GS:   rd_val = q.sv_gs;
      `ERCC_OFF_FS_LIM:  rd_val = q.fs_lim;
      `ERCC_OFF_GS_LIM:  rd_val = q.gs_lim;
      `ERCC_OFF_SV_XCR:  rd_val = q.sv_xcr;
      `ERCC_OFF_DBG:     rd_val = q.dbg;
      `ERCC_OFF_PERF:    rd_val = q.perf;
      default:           rd_hit = 1'b0;
    endcase
  end

  //--------------------------------------------------------------
  // resume checks
  //--------------------------------------------------------------
  assign wide   = q.cond[`ERCC_C_WIDE];
  // 32-bit mode spans base plus limit; wide mode only the base
  assign fs_end = wide ? {1'b0, q.fs_ofs}
                       : {1'b0, q.fs_ofs} + {1'b0, q.fs_lofs};
  assign gs_end = wide ? {1'b0, q.gs_ofs}
                       : {1'b0, q.gs_ofs} + {1'b0, q.gs_lofs};

  // priority chain: earliest check names the cause
  always_comb begin
    cause = CS_NONE;
    if (!q.cond[`ERCC_C_INENCL]) begin
      cause = CS_OUTSIDE;                                   // see [RULE_02]
    end else if (wide && (q.hptr_hi[31:15] != {17{q.hptr_hi[15]}})) begin
      cause = CS_NONCANON;                                  // see [RULE_03]
    end else if (!wide && (q.hptr_lo > q.ds_lim)) begin
      cause = CS_LIMIT;                                     // see [RULE_04]
    end else if ((q.csp[11:0] != 12'h000) || q.cond[`ERCC_C_MISALIGN]
                 || q.cond[`ERCC_C_FOREIGN]) begin
      cause = CS_OPERAND;                                   // see [RULE_06]
    end else if (q.tflags != 32'h0000_0000) begin
      cause = CS_FLAGS;                                     // see [RULE_07]
    end else if (wide != q.cond[`ERCC_C_ATTR_WIDE]) begin
      cause = CS_MODE;                                      // see [RULE_08]
    end else if (q.cond[`ERCC_C_THREAD_BAD] || q.cond[`ERCC_C_ECS_BUSY]
                 || q.cond[`ERCC_C_CONFLICT]) begin
      cause = CS_THREAD;                                    // see [RULE_09]
    end else if (fs_end[32] || gs_end[32] || (fs_end[31:0] > q.ds_lim)
                 || (gs_end[31:0] > q.ds_lim)) begin
      cause = CS_FSGS;                                      // see [RULE_10]
    end else if (q.cond[`ERCC_C_SEG_NZ]) begin
      cause = CS_SEGBASE;                                   // see [RULE_11]
    end else if (q.cond[`ERCC_C_XAVAIL] && !q.cond[`ERCC_C_XSV_EN]
                 && (q.fmask != `ERCC_MASK_LEGACY)) begin
      cause = CS_XLEGACY;                                   // see [RULE_12]
    end else if (!q.cond[`ERCC_C_FXSR] || (q.cond[`ERCC_C_XSV_EN]
                 && ((q.fmask & ~q.xcr) != 32'h0000_0000))) begin
      cause = CS_XCTRL;                                     // see [RULE_13]
    end else if (q.cond[`ERCC_C_XHDR_NZ]
                 || ((q.xbv & ~q.fmask) != 32'h0000_0000)) begin
      cause = CS_XHDR;                                      // see [RULE_14]
    end else if (q.cond[`ERCC_C_FRAME_BAD]) begin
      cause = CS_FRAME;                                     // see [RULE_15]
    end else if (q.cond[`ERCC_C_PF]) begin
      cause = CS_PAGE;                                      // see [RULE_05]
    end
  end

  //--------------------------------------------------------------
  // next state
  //--------------------------------------------------------------
  always_comb begin
    d      = q;
    wr_hit = 1'b1;
    // address and data are taken independently, in either order
    if (AWVALID_I && AWREADY_O) begin
      d.aw_have = 1'b1;
      d.aw_addr = AWADDR_I;
    end
    if (WVALID_I && WREADY_O) begin
      d.w_have = 1'b1;
      d.w_data = WDATA_I;
      d.w_strb = WSTRB_I;
    end
    if (BVALID_O && BREADY_I) begin
      d.bvalid = 1'b0;
    end
    if (RVALID_O && RREADY_I) begin
      d.rvalid = 1'b0;
    end
    // read answer registered on the same edge that takes the address
    if (ARVALID_I && ARREADY_O) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_hit ? `ERCC_RESP_OKAY : `ERCC_RESP_SLVERR;
    end

    // register write once both halves are held
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      case (q.aw_addr)
        `ERCC_OFF_FUNC:    d.func    = merge(q.func, q.w_data, q.w_strb);
        `ERCC_OFF_COND:    d.cond    = merge(q.cond, q.w_data, q.w_strb);
        `ERCC_OFF_HPTR_LO: d.hptr_lo = merge(q.hptr_lo, q.w_data, q.w_strb);
        `ERCC_OFF_HPTR_HI: d.hptr_hi = merge(q.hptr_hi, q.w_data, q.w_strb);
        `ERCC_OFF_CSP:     d.csp     = merge(q.csp, q.w_data, q.w_strb);
        `ERCC_OFF_DS_LIM:  d.ds_lim  = merge(q.ds_lim, q.w_data, q.w_strb);
        `ERCC_OFF_TFLAGS:  d.tflags  = merge(q.tflags, q.w_data, q.w_strb);
        `ERCC_OFF_FMASK:   d.fmask   = merge(q.fmask, q.w_data, q.w_strb);
        `ERCC_OFF_XCR:     d.xcr     = merge(q.xcr, q.w_data, q.w_strb);
        `ERCC_OFF_XBV:     d.xbv     = merge(q.xbv, q.w_data, q.w_strb);
        `ERCC_OFF_FS_OFS:  d.fs_ofs  = merge(q.fs_ofs, q.w_data, q.w_strb);
        `ERCC_OFF_GS_OFS:  d.gs_ofs  = merge(q.gs_ofs, q.w_data, q.w_strb);
        `ERCC_OFF_FS_LOFS: d.fs_lofs = merge(q.fs_lofs, q.w_data, q.w_strb);
        `ERCC_OFF_GS_LOFS: d.gs_lofs = merge(q.gs_lofs, q.w_data, q.w_strb);
        `ERCC_OFF_PERF:    d.perf    = q.perf & ~(q.w_data & {
                             {8{q.w_strb[3]}}, {8{q.w_strb[2]}},
                             {8{q.w_strb[1]}}, {8{q.w_strb[0]}}});
        `ERCC_OFF_CMD: begin
          // a go while busy is dropped; status shows busy meanwhile
          if (q.w_strb[0] && q.w_data[`ERCC_CMD_GO]
              && (q.st == EX_IDLE)) begin
            d.st     = EX_CHECK;
            d.status = 32'h0000_0000;
            d.status[`ERCC_S_BUSY] = 1'b1;
          end
          // a flag pop setting the trap flag is defeated in opt-out
          if (q.w_strb[0] && q.w_data[`ERCC_CMD_FLAGPOP]) begin
            d.dbg[`ERCC_D_TRAP] = !(q.dbg[`ERCC_D_ACTIVE]
                                  && q.cond[`ERCC_C_OPTOUT]); // see [RULE_19]
          end
          if (q.w_strb[0] && q.w_data[`ERCC_CMD_RETIRE]) begin
            d.dbg[`ERCC_D_PEND_SS] = 1'b0;
          end
          // exit puts back what entry saved and lifts suppression
          if (q.w_strb[0] && q.w_data[`ERCC_CMD_EXIT]
              && q.dbg[`ERCC_D_ACTIVE]) begin
            d.dbg[`ERCC_D_TRAP] = q.dbg[`ERCC_D_SV_TRAP];     // see [RULE_19]
            d.dbg[8:3] = 6'h00;
            d.fs  = q.sv_fs;
            d.gs  = q.sv_gs;
            d.xcr = q.sv_xcr;
          end
        end
        default: wr_hit = 1'b0;
      endcase
      d.bresp = wr_hit ? `ERCC_RESP_OKAY : `ERCC_RESP_SLVERR;
    end

    // sequencer: decide, then commit in a separate cycle
    case (q.st)
      EX_IDLE: begin
        // stays idle unless a go write above has already moved d.st
      end
      EX_CHECK: begin
        d.status[`ERCC_S_BUSY] = 1'b0;
        if (q.func != `ERCC_LEAF_RESUME) begin
          d.st = EX_IDLE;                                   // see [RULE_01]
          d.status[`ERCC_S_DONE]    = 1'b1;
          d.status[`ERCC_S_IGNORED] = 1'b1;
        end else if (cause != CS_NONE) begin
          // nothing architectural changes on the fault path
          d.st = EX_IDLE;                                   // see [RULE_23]
          d.status[`ERCC_S_DONE] = 1'b1;
          d.status[`ERCC_S_PF]   = (cause == CS_PAGE);      // see [RULE_05]
          d.status[`ERCC_S_GP]   = (cause != CS_PAGE);
          d.status[15:8]         = cause;
        end else begin
          d.st = EX_COMMIT;
          d.status[`ERCC_S_BUSY] = 1'b1;
        end
      end
      EX_COMMIT: begin
        d.st = EX_IDLE;
        d.status[`ERCC_S_BUSY] = 1'b0;
        d.status[`ERCC_S_DONE] = 1'b1;
        d.xp_lo  = q.hptr_lo;                               // see [RULE_16]
        d.xp_hi  = q.hptr_hi;
        d.sv_fs  = q.fs;                                    // see [RULE_17]
        d.sv_gs  = q.gs;
        d.fs     = q.fs_ofs;
        d.gs     = q.gs_ofs;
        if (!wide) begin
          d.fs_lim = q.fs_lofs;
          d.gs_lim = q.gs_lofs;
        end
        if (q.cond[`ERCC_C_XSV_EN]) begin
          d.sv_xcr = q.xcr;                                 // see [RULE_18]
          d.xcr    = q.fmask;
        end
        d.dbg[`ERCC_D_ACTIVE] = 1'b1;
        d.dbg[`ERCC_D_BP_OUT] = 1'b1;                       // see [RULE_21]
        if (q.cond[`ERCC_C_OPTOUT]) begin
          d.dbg[`ERCC_D_SV_TRAP]  = q.dbg[`ERCC_D_TRAP];    // see [RULE_19]
          d.dbg[`ERCC_D_TRAP]     = 1'b0;
          d.dbg[`ERCC_D_BP_IN]    = 1'b1;                   // see [RULE_21]
          d.dbg[`ERCC_D_PERF_SUP] = 1'b1;                   // see [RULE_22]
          d.dbg[`ERCC_D_PREC_SUP] = 1'b1;
          d.dbg[`ERCC_D_DEMOTE]   = 1'b1;
          // set wins over a clear written in the same cycle
          d.perf[`ERCC_P_B60] = 1'b1;
          d.perf[`ERCC_P_B63] = 1'b1;
        end else begin
          d.dbg[`ERCC_D_PEND_SS] = 1'b1;                    // see [RULE_20]
          // no opt-out suppression may linger from an earlier entry
          d.dbg[7:4] = 4'h0;
        end
      end
      default: d.st = EX_IDLE;
    endcase
  end

  //--------------------------------------------------------------
  // state register
  //--------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      q    <= '0;
      q.st <= EX_IDLE;
    end else begin
      q <= d;
    end
  end

  // handshakes combinational, data from flip-flops
  assign AWREADY_O = !q.aw_have && !q.bvalid;
  assign WREADY_O  = !q.w_have && !q.bvalid;
  assign BVALID_O  = q.bvalid;
  assign BRESP_O   = q.bresp;
  assign ARREADY_O = !q.rvalid;
  assign RVALID_O  = q.rvalid;
  assign RDATA_O   = q.rdata;
  assign RRESP_O   = q.rresp;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic [31:0] xp_seen;
  assign xp_seen = q.xp_lo;

  sequence s_check_ok;
    q.st == EX_CHECK && q.func == `ERCC_LEAF_RESUME && cause == CS_NONE;
  endsequence

  chk_leaf_ignore: assert property ( // see [RULE_01]
    (q.st == EX_CHECK && q.func != `ERCC_LEAF_RESUME)
    |=> q.status[`ERCC_S_IGNORED] && !q.status[`ERCC_S_GP]
        && q.st == EX_IDLE)
    else $error("wrong leaf was not ignored");

  chk_outside_gp: assert property ( // see [RULE_02]
    (q.st == EX_CHECK && q.func == `ERCC_LEAF_RESUME
     && !q.cond[`ERCC_C_INENCL])
    |=> q.status[`ERCC_S_GP] && q.status[15:8] == CS_OUTSIDE)
    else $error("outside enclave did not raise gp");

  chk_fault_quiet: assert property ( // see [RULE_23]
    (q.st == EX_CHECK && cause != CS_NONE)
    |=> q.st == EX_IDLE && $stable(xp_seen) ##1 $stable(xp_seen))
    else $error("faulting resume changed state");

  chk_commit_xp: assert property ( // see [RULE_16]
    s_check_ok ##1 (q.st == EX_COMMIT)
    |=> xp_seen == $past(q.hptr_lo, 2) && q.status[`ERCC_S_DONE])
    else $error("handler pointer not stored");

  chk_xcr_swap: assert property ( // see [RULE_18]
    (q.st == EX_COMMIT && q.cond[`ERCC_C_XSV_EN])
    |=> q.xcr == $past(q.fmask) && q.sv_xcr == $past(q.xcr))
    else $error("feature control not swapped");

  chk_optout_trap: assert property ( // see [RULE_19]
    (q.st == EX_COMMIT && q.cond[`ERCC_C_OPTOUT])
    |=> !q.dbg[`ERCC_D_TRAP]
        && q.dbg[`ERCC_D_SV_TRAP] == $past(q.dbg[`ERCC_D_TRAP]))
    else $error("trap flag not saved and cleared");

  chk_optin_pend: assert property ( // see [RULE_20]
    (q.st == EX_COMMIT && !q.cond[`ERCC_C_OPTOUT])
    |=> q.dbg[`ERCC_D_PEND_SS] && !q.dbg[`ERCC_D_PERF_SUP])
    else $error("single step not pended");

  chk_perf_bits: assert property ( // see [RULE_22]
    (q.st == EX_COMMIT && q.cond[`ERCC_C_OPTOUT])
    |=> q.perf[`ERCC_P_B60] && q.perf[`ERCC_P_B63]
        && q.dbg[`ERCC_D_PREC_SUP])
    else $error("monitor suppression bits not set");

  chk_seg_build: assert property ( // see [RULE_17]
    (q.st == EX_COMMIT)
    |=> q.fs == $past(q.fs_ofs) && q.sv_fs == $past(q.fs))
    else $error("segment base not rebuilt");

endmodule

// ===== shared/ercc_defs.svh
`ifndef ERCC_DEFS_SVH
`define ERCC_DEFS_SVH

// register byte offsets
`define ERCC_OFF_FUNC     8'h00
`define ERCC_OFF_CMD      8'h04
`define ERCC_OFF_COND     8'h08
`define ERCC_OFF_HPTR_LO  8'h0C
`define ERCC_OFF_HPTR_HI  8'h10
`define ERCC_OFF_CSP      8'h14
`define ERCC_OFF_DS_LIM   8'h18
`define ERCC_OFF_TFLAGS   8'h1C
`define ERCC_OFF_FMASK    8'h20
`define ERCC_OFF_XCR      8'h24
`define ERCC_OFF_XBV      8'h28
`define ERCC_OFF_FS_OFS   8'h2C
`define ERCC_OFF_GS_OFS   8'h30
`define ERCC_OFF_FS_LOFS  8'h34
`define ERCC_OFF_GS_LOFS  8'h38
`define ERCC_OFF_STATUS   8'h3C
`define ERCC_OFF_XP_LO    8'h40
`define ERCC_OFF_XP_HI    8'h44
`define ERCC_OFF_FS       8'h48
`define ERCC_OFF_GS       8'h4C
`define ERCC_OFF_SV_FS    8'h50
`define ERCC_OFF_SV_GS    8'h54
`define ERCC_OFF_FS_LIM   8'h58
`define ERCC_OFF_GS_LIM   8'h5C
`define ERCC_OFF_SV_XCR   8'h60
`define ERCC_OFF_DBG      8'h64
`define ERCC_OFF_PERF     8'h68

// command bits
`define ERCC_CMD_GO       0
`define ERCC_CMD_FLAGPOP  1
`define ERCC_CMD_EXIT     2
`define ERCC_CMD_RETIRE   3
// condition bits
`define ERCC_C_INENCL     0
`define ERCC_C_WIDE       1
`define ERCC_C_ATTR_WIDE  2
`define ERCC_C_XAVAIL     3
`define ERCC_C_XSV_EN     4
`define ERCC_C_FXSR       5
`define ERCC_C_OPTOUT     6
`define ERCC_C_PF         7
`define ERCC_C_MISALIGN   8
`define ERCC_C_FOREIGN    9
`define ERCC_C_THREAD_BAD 10
`define ERCC_C_ECS_BUSY   11
`define ERCC_C_CONFLICT   12
`define ERCC_C_FRAME_BAD  13
`define ERCC_C_SEG_NZ     14
`define ERCC_C_XHDR_NZ    15
// status bits
`define ERCC_S_DONE       0
`define ERCC_S_GP         1
`define ERCC_S_PF         2
`define ERCC_S_IGNORED    3
`define ERCC_S_BUSY       4
// debug bits
`define ERCC_D_TRAP       0
`define ERCC_D_SV_TRAP    1
`define ERCC_D_PEND_SS    2
`define ERCC_D_BP_OUT     3
`define ERCC_D_BP_IN      4
`define ERCC_D_PERF_SUP   5
`define ERCC_D_PREC_SUP   6
`define ERCC_D_DEMOTE     7
`define ERCC_D_ACTIVE     8
// high word of the overflow status: bits 60 and 63
`define ERCC_P_B60        28
`define ERCC_P_B63        31

`define ERCC_LEAF_RESUME  32'h0000_0003
`define ERCC_MASK_LEGACY  32'h0000_0003
`define ERCC_RESP_OKAY    2'h0
`define ERCC_RESP_SLVERR  2'h2

`endif

// ===== shared/ercc_pkg.sv
package ercc_pkg;

  // execution sequencer, one-hot
  typedef enum logic [2:0] {
    EX_IDLE   = 3'b001,
    EX_CHECK  = 3'b010,
    EX_COMMIT = 3'b100
  } ercc_ex_t;

  // fault causes, first failing check wins
  typedef enum logic [7:0] {
    CS_NONE     = 8'h00,
    CS_OUTSIDE  = 8'h01,
    CS_NONCANON = 8'h02,
    CS_LIMIT    = 8'h03,
    CS_OPERAND  = 8'h04,
    CS_FLAGS    = 8'h05,
    CS_MODE     = 8'h06,
    CS_THREAD   = 8'h07,
    CS_FSGS     = 8'h08,
    CS_SEGBASE  = 8'h09,
    CS_XLEGACY  = 8'h0A,
    CS_XCTRL    = 8'h0B,
    CS_XHDR     = 8'h0C,
    CS_FRAME    = 8'h0D,
    CS_PAGE     = 8'h0E
  } ercc_cause_t;

  typedef struct packed {
    ercc_ex_t    st;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] func;
    logic [31:0] cond;
    logic [31:0] hptr_lo;
    logic [31:0] hptr_hi;
    logic [31:0] csp;
    logic [31:0] ds_lim;
    logic [31:0] tflags;
    logic [31:0] fmask;
    logic [31:0] xcr;
    logic [31:0] xbv;
    logic [31:0] fs_ofs;
    logic [31:0] gs_ofs;
    logic [31:0] fs_lofs;
    logic [31:0] gs_lofs;
    logic [31:0] status;
    logic [31:0] xp_lo;
    logic [31:0] xp_hi;
    logic [31:0] fs;
    logic [31:0] gs;
    logic [31:0] sv_fs;
    logic [31:0] sv_gs;
    logic [31:0] fs_lim;
    logic [31:0] gs_lim;
    logic [31:0] sv_xcr;
    logic [31:0] dbg;
    logic [31:0] perf;
  } ercc_state_t;

endpackage
